/* File: bbac_alarm_capture.sv */
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "bbac_params.svh"
// Overview of operation
// R1 - A charger sends an alarm notify whenever battery or adapter status changes.
// R2 - Plain charger alarm data holds its charger_state_cmd register, code 0x13.
// R3 - Any charger alarm is stored with alarm address 0x09.
// R4 - Address and data are captured, then alarm status set, then interrupt raised.
// R5 - Charger flags an integrated manager or selector in charger_capability_cmd bit 4.
// R6 - Integrated manager sends code 0x21, integrated selector 0x01; address stays charger.
// R7 - A standalone manager sends an alarm notify on battery or adapter change.
// R8 - Standalone manager alarm stores pack_system_state_cmd 0x01 data and address 0x0A.
// R9 - A standalone selector acts as a manager, its data from pack_selector_state_cmd.
// R10 - Stored address is the 7-bit address shifted left with the write bit.
// R11 - Battery count 0 to 4; zero means no manager or selector.
// R12 - Alarms are received as a bus slave at host address 0x8.
// R13 - Captured address and data hold until software clears the alarm bit.
module bbac_alarm_capture (
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Battery link pins, open drain.
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,

    // Interrupt to the system.
    output logic system_control_irq
);
    import bbac_pkg::*;

    bbac_core_state_t s;
    bbac_core_state_t next_s;

    // Synchronised link lines and their edges.
    logic [1:0] pinLevel;
    logic [1:0] pinRise;
    logic [1:0] pinFall;

    // Sticky status and enable, also the capture lock.
    logic [2:0] irqStatus;
    logic [2:0] irqEnable;

    // Named views of the link lines.
    logic sclLevel;
    logic sclRise;
    logic sclFall;
    logic sdaLevel;
    logic startSeen;
    logic stopSeen;
    logic alarmPending;

    // Register bus decode.
    logic apbSetup;
    logic apbWrite;
    logic addrMapped;
    logic clrWrite;
    logic enWrite;

    // Configuration view and source class.
    logic managerPresent;
    bbac_src_t decKind;
    logic [7:0] decCmd;

    // Both link lines come from another party and pass the synchroniser first.
    bbac_link_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn({sdaIn, sclIn}),
        .level(pinLevel),
        .rise(pinRise),
        .fall(pinFall)
    );

    // Bit 0 is the clock line, bit 1 the data line.
    assign sclLevel = pinLevel[0];
    assign sclRise = pinRise[0];
    assign sclFall = pinFall[0];
    assign sdaLevel = pinLevel[1];

    // Start and stop are data edges while the clock line stands high.
    assign startSeen = pinFall[1] & sclLevel;
    assign stopSeen = pinRise[1] & sclLevel;

    // A set alarm bit locks the capture registers against the next message.
    assign alarmPending = irqStatus[`BBAC_EVT_ALARM]; // R13

    // A nonzero battery count means a manager or selector sits on the bus.
    assign managerPresent = (s.cfgCount != `BBAC_CFG_COUNT_RESET); // R11

    // The open-drain data line is only ever pulled low, never driven high.
    // Pulling low only avoids fighting the pull-up.
    assign sdaOut = 1'b0;
    assign sdaOe = s.sdaLow;

    // APB decode; the slave never inserts wait states.
    // Reads stand from the setup edge, so no access needs a second cycle.
    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pwrite;
    assign pready = 1'b1;
    assign prdata = s.prdata;

    // Offsets that answer; all others are unmapped.
    always_comb begin
        case (paddr)
            `BBAC_OFS_ALARM_ADDR,
            `BBAC_OFS_ALARM_DATA,
            `BBAC_OFS_STATUS,
            `BBAC_OFS_CLEAR,
            `BBAC_OFS_ENABLE,
            `BBAC_OFS_CONFIG,
            `BBAC_OFS_INFO: begin
                addrMapped = 1'b1;
            end
            default: begin
                addrMapped = 1'b0;
            end
        endcase
    end

    // Unmapped offsets answer with an error; writes to read-only words are dropped.
    assign pslverr = psel & penable & ~addrMapped;
    assign clrWrite = apbWrite & (paddr == `BBAC_OFS_CLEAR);
    assign enWrite = apbWrite & (paddr == `BBAC_OFS_ENABLE);

    // Classify the originator from the stored address byte and the configuration.
    // A read bit, a foreign address, or the manager address with a zero battery count gives kind unknown.
    always_comb begin
        decKind = BBAC_SRC_UNKNOWN;
        decCmd = `BBAC_CMD_NONE;
        if (s.rxAddr[0] != `BBAC_WRITE_BIT) begin // R10
            decKind = BBAC_SRC_UNKNOWN;
            decCmd = `BBAC_CMD_NONE;
        end else if (s.rxAddr[7:1] == `BBAC_CHARGER_ADDR) begin // R3
            decKind = BBAC_SRC_CHARGER;
            // The charger's flags choose the register its data carries.
            if (!s.cfgIntegrated) begin
                decCmd = `BBAC_CMD_CHARGER_STATE; // R2
            end else if (s.cfgSelector) begin
                decCmd = `BBAC_CMD_PACK_SELECTOR_STATE; // R6
            end else begin
                decCmd = `BBAC_CMD_PACK_SYSTEM_STATE_INT; // R6
            end
        end else if (s.rxAddr[7:1] == `BBAC_MANAGER_ADDR && managerPresent) begin // R11
            decKind = BBAC_SRC_MANAGER;
            // A manager is expected only with a nonzero battery count.
            if (s.cfgSelector) begin
                decCmd = `BBAC_CMD_PACK_SELECTOR_STATE; // R9
            end else begin
                decCmd = `BBAC_CMD_PACK_SYSTEM_STATE; // R8
            end
        end
    end

    // Receiver and register next state.
    always_comb begin
        next_s = s;
        next_s.evt = `BBAC_EVT_RESET;
        // Event pulses last one cycle; the interrupt block holds them.

        // Stop and start end or restart a message from any state.
        if (stopSeen) begin
            next_s.rx = BBAC_IDLE;
            next_s.sdaLow = 1'b0;
        end else if (startSeen) begin
            next_s.rx = BBAC_RECV;
            next_s.bitCount = 4'h0;
            next_s.byteIndex = `BBAC_BYTE_OWN_ADDR;
            next_s.sdaLow = 1'b0;
        end else begin
            case (s.rx)
                BBAC_IDLE: begin
                    // Wait for a start.
                    next_s.sdaLow = 1'b0;
                end
                BBAC_RECV: begin
                    // Data is sampled when the clock line rises, most significant bit first.
                    // The count stops at eight.
                    if (sclRise && s.bitCount != `BBAC_BITS_PER_BYTE) begin
                        next_s.shiftByte = {s.shiftByte[6:0], sdaLevel};
                        next_s.bitCount = s.bitCount + 4'h1;
                    end

                    // After the eighth bit the acknowledge is decided on the falling clock.
                    if (sclFall && s.bitCount == `BBAC_BITS_PER_BYTE) begin
                        next_s.bitCount = 4'h0;
                        case (s.byteIndex)
                            `BBAC_BYTE_OWN_ADDR: begin
                                if (s.shiftByte != {`BBAC_HOST_SLAVE_ADDR, `BBAC_WRITE_BIT}) begin // R12
                                    next_s.rx = BBAC_SKIP;
                                end else if (alarmPending) begin // R13
                                    // Refusing keeps the held alarm intact; the sender retries.
                                    next_s.rx = BBAC_SKIP;
                                    next_s.evt[`BBAC_EVT_REFUSED] = 1'b1;
                                end else begin
                                    next_s.rx = BBAC_ACK;
                                    next_s.sdaLow = 1'b1;
                                end
                            end
                            `BBAC_BYTE_SRC_ADDR: begin
                                next_s.rxAddr = s.shiftByte; // R10
                                next_s.rx = BBAC_ACK;
                                next_s.sdaLow = 1'b1;
                            end
                            `BBAC_BYTE_DATA_LOW: begin
                                // Held until the high byte arrives.
                                next_s.rxLow = s.shiftByte;
                                next_s.rx = BBAC_ACK;
                                next_s.sdaLow = 1'b1;
                            end
                            default: begin
                                // Whole message received: load address and data, then flag it.
                                next_s.alarmAddr = s.rxAddr; // R3
                                next_s.alarmData = {s.shiftByte, s.rxLow}; // R2
                                next_s.srcKind = decKind;
                                next_s.srcCmd = decCmd;
                                next_s.evt[`BBAC_EVT_ALARM] = 1'b1; // R4
                                next_s.evt[`BBAC_EVT_UNKNOWN] = (decKind == BBAC_SRC_UNKNOWN);
                                next_s.rx = BBAC_ACK;
                                next_s.sdaLow = 1'b1;
                            end
                        endcase
                    end
                end
                BBAC_ACK: begin
                    // The line is released on the falling clock that ends the ninth bit.
                    if (sclFall) begin
                        next_s.sdaLow = 1'b0;
                        if (s.byteIndex == `BBAC_BYTE_DATA_HIGH) begin
                            next_s.rx = BBAC_SKIP;
                        end else begin
                            next_s.byteIndex = s.byteIndex + 2'h1;
                            next_s.rx = BBAC_RECV;
                        end
                    end
                end
                BBAC_SKIP: begin
                    // Extra bytes and foreign traffic are left unacknowledged.
                    next_s.sdaLow = 1'b0;
                end
                default: begin
                    // An illegal state returns to idle.
                    next_s.rx = BBAC_IDLE;
                    next_s.sdaLow = 1'b0;
                end
            endcase
        end

        // Configuration write; a battery count above the maximum is ignored.
        // The flags are taken even when the count is refused.
        if (apbWrite && paddr == `BBAC_OFS_CONFIG) begin
            if (pwdata[`BBAC_CFG_COUNT_MSB:0] <= `BBAC_MAX_BATTERIES) begin // R11
                next_s.cfgCount = pwdata[`BBAC_CFG_COUNT_MSB:0];
            end
            next_s.cfgIntegrated = pwdata[`BBAC_CFG_INTEGRATED_BIT]; // R5
            next_s.cfgSelector = pwdata[`BBAC_CFG_SELECTOR_BIT];
        end

        // Read data is loaded in the setup cycle and stands through the access cycle.
        if (apbSetup) begin
            next_s.prdata = 32'h0;
            case (paddr)
                `BBAC_OFS_ALARM_ADDR: begin
                    next_s.prdata[7:0] = s.alarmAddr;
                end
                `BBAC_OFS_ALARM_DATA: begin
                    next_s.prdata[15:0] = s.alarmData;
                end
                `BBAC_OFS_STATUS: begin
                    next_s.prdata[2:0] = irqStatus;
                end
                `BBAC_OFS_ENABLE: begin
                    next_s.prdata[2:0] = irqEnable;
                end
                `BBAC_OFS_CONFIG: begin
                    next_s.prdata[`BBAC_CFG_COUNT_MSB:0] = s.cfgCount;
                    next_s.prdata[`BBAC_CFG_INTEGRATED_BIT] = s.cfgIntegrated;
                    next_s.prdata[`BBAC_CFG_SELECTOR_BIT] = s.cfgSelector;
                end
                `BBAC_OFS_INFO: begin
                    // Busy helps software avoid racing a capture.
                    next_s.prdata[7:0] = s.srcCmd;
                    next_s.prdata[9:8] = s.srcKind;
                    next_s.prdata[10] = managerPresent;
                    next_s.prdata[11] = (s.rx != BBAC_IDLE);
                end
                default: begin
                    next_s.prdata = 32'h0;
                end
            endcase
        end
    end

    // Single state register of the block.
    // Reset leaves the receiver idle and nothing captured.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s.rx <= BBAC_IDLE;
            s.shiftByte <= 8'h00;
            s.bitCount <= 4'h0;
            s.byteIndex <= `BBAC_BYTE_OWN_ADDR;
            s.sdaLow <= 1'b0;
            s.rxAddr <= 8'h00;
            s.rxLow <= 8'h00;
            s.alarmAddr <= 8'h00;
            s.alarmData <= 16'h0000;
            s.srcKind <= BBAC_SRC_NONE;
            s.srcCmd <= `BBAC_CMD_NONE;
            s.cfgCount <= `BBAC_CFG_COUNT_RESET;
            s.cfgIntegrated <= 1'b0;
            s.cfgSelector <= 1'b0;
            s.evt <= `BBAC_EVT_RESET;
            s.prdata <= 32'h0;
        end else begin
            s <= next_s;
        end
    end

    // Sticky events, enable mask and the interrupt line.
    // Registered, so the interrupt trails status by a cycle.
    bbac_irq_ctrl u_irq (
        .clk_sys(clk_sys),
        .rst(rst),
        .evt(s.evt),
        .clrWrite(clrWrite),
        .enWrite(enWrite),
        .wdata(pwdata[2:0]),
        .status(irqStatus),
        .enable(irqEnable),
        .irq(system_control_irq)
    );
endmodule : bbac_alarm_capture

/* File: bbac_params.svh */
`ifndef BBAC_PARAMS_SVH
`define BBAC_PARAMS_SVH

// Bus addresses on the battery link, as 7-bit slave addresses.
`define BBAC_HOST_SLAVE_ADDR 7'h08
`define BBAC_CHARGER_ADDR 7'h09
`define BBAC_MANAGER_ADDR 7'h0A
`define BBAC_WRITE_BIT 1'b0

// Command codes whose contents an alarm carries, and the charger capability code.
`define BBAC_CMD_NONE 8'h00
`define BBAC_CMD_CHARGER_STATE 8'h13
`define BBAC_CMD_CHARGER_CAPABILITY 8'h11
`define BBAC_CMD_PACK_SYSTEM_STATE_INT 8'h21
`define BBAC_CMD_PACK_SYSTEM_STATE 8'h01
`define BBAC_CMD_PACK_SELECTOR_STATE 8'h01

// Byte framing of one alarm message.
`define BBAC_BITS_PER_BYTE 4'h8
`define BBAC_BYTE_OWN_ADDR 2'h0
`define BBAC_BYTE_SRC_ADDR 2'h1
`define BBAC_BYTE_DATA_LOW 2'h2
`define BBAC_BYTE_DATA_HIGH 2'h3

// Register byte offsets on the APB.
`define BBAC_OFS_ALARM_ADDR 8'h00
`define BBAC_OFS_ALARM_DATA 8'h04
`define BBAC_OFS_STATUS 8'h08
`define BBAC_OFS_CLEAR 8'h0C
`define BBAC_OFS_ENABLE 8'h10
`define BBAC_OFS_CONFIG 8'h14
`define BBAC_OFS_INFO 8'h18

// Configuration fields: battery count, integrated function, selector kind.
`define BBAC_CFG_COUNT_MSB 2
`define BBAC_CFG_INTEGRATED_BIT 4
`define BBAC_CFG_SELECTOR_BIT 5
`define BBAC_MAX_BATTERIES 3'h4
`define BBAC_CFG_COUNT_RESET 3'h0

// Event and status bit positions.
`define BBAC_EVT_WIDTH 3
`define BBAC_EVT_ALARM 0
`define BBAC_EVT_UNKNOWN 1
`define BBAC_EVT_REFUSED 2
`define BBAC_EVT_RESET 3'h0

`endif

/* File: bbac_pkg.sv */
package bbac_pkg;

    // Receiver states, one-hot.
    typedef enum logic [3:0] {
        BBAC_IDLE = 4'b0001,
        BBAC_RECV = 4'b0010,
        BBAC_ACK = 4'b0100,
        BBAC_SKIP = 4'b1000
    } bbac_rx_state_t;

    // Who sent the latest alarm.
    typedef enum logic [1:0] {
        BBAC_SRC_NONE = 2'h0,
        BBAC_SRC_CHARGER = 2'h1,
        BBAC_SRC_MANAGER = 2'h2,
        BBAC_SRC_UNKNOWN = 2'h3
    } bbac_src_t;

    typedef struct packed {
        logic [1:0] stage1;
        logic [1:0] stage2;
        logic [1:0] prev;
    } bbac_sync_state_t;

    typedef struct packed {
        logic [2:0] status;
        logic [2:0] enable;
        logic irq;
    } bbac_irq_state_t;

    typedef struct packed {
        bbac_rx_state_t rx;
        logic [7:0] shiftByte;
        logic [3:0] bitCount;
        logic [1:0] byteIndex;
        logic sdaLow;
        logic [7:0] rxAddr;
        logic [7:0] rxLow;
        logic [7:0] alarmAddr;
        logic [15:0] alarmData;
        bbac_src_t srcKind;
        logic [7:0] srcCmd;
        logic [2:0] cfgCount;
        logic cfgIntegrated;
        logic cfgSelector;
        logic [2:0] evt;
        logic [31:0] prdata;
    } bbac_core_state_t;

endpackage : bbac_pkg

/* File: bbac_link_sync.sv */
`timescale 1ns/1ps
module bbac_link_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] pinIn,
    output logic [1:0] level,
    output logic [1:0] rise,
    output logic [1:0] fall
);
    import bbac_pkg::*;

    bbac_sync_state_t s;
    bbac_sync_state_t next_s;

    // Three flops per pin; only the second stage and its delayed copy feed edge logic.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_pin
            assign level[i] = s.stage2[i];
            assign rise[i] = s.stage2[i] & ~s.prev[i];
            assign fall[i] = ~s.stage2[i] & s.prev[i];
        end
    endgenerate

    // Shift chain of the synchroniser.
    always_comb begin
        next_s = s;
        next_s.stage1 = pinIn;
        next_s.stage2 = s.stage1;
        next_s.prev = s.stage2;
    end

    // Idle bus lines are high, so reset to high avoids a false edge at release.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '{stage1: 2'h3, stage2: 2'h3, prev: 2'h3};
        end else begin
            s <= next_s;
        end
    end
endmodule : bbac_link_sync

/* File: bbac_irq_ctrl.sv */
`timescale 1ns/1ps
`include "bbac_params.svh"
module bbac_irq_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] evt,
    input wire logic clrWrite,
    input wire logic enWrite,
    input wire logic [2:0] wdata,
    output logic [2:0] status,
    output logic [2:0] enable,
    output logic irq
);
    import bbac_pkg::*;

    bbac_irq_state_t s;
    bbac_irq_state_t next_s;

    assign status = s.status;
    assign enable = s.enable;
    assign irq = s.irq;

    // Sticky status per bit; an event in the clearing cycle wins over the clear.
    always_comb begin
        next_s = s;
        for (int i = 0; i < `BBAC_EVT_WIDTH; i++) begin
            next_s.status[i] = evt[i] | (s.status[i] & ~(clrWrite & wdata[i]));
        end
        if (enWrite) begin
            next_s.enable = wdata;
        end
        // Registered, so the line rises the cycle after the status bit.
        next_s.irq = |(s.status & s.enable); // R4
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '{status: `BBAC_EVT_RESET, enable: `BBAC_EVT_RESET, irq: 1'b0};
        end else begin
            s <= next_s;
        end
    end
endmodule : bbac_irq_ctrl

/* File: bbac_alarm_monitor.sv */
`timescale 1ns/1ps
module bbac_alarm_monitor (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic system_control_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Access phase of a bus transfer, shared by the bus properties.
    wire logic acc = psel && penable;
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("Bus answer not ready.");
    property p_errmap; acc && paddr > 8'h18 |-> pslverr; endproperty
    a_errmap: assert property (p_errmap) else $error("Unmapped access without error.");
    property p_okmap; acc && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_okmap: assert property (p_okmap) else $error("Mapped access flagged as error.");
    property p_errphase; pslverr |-> acc; endproperty
    a_errphase: assert property (p_errphase) else $error("Error outside access phase.");
    property p_zero; psel && !penable && paddr > 8'h18 |=> prdata == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("Unmapped read not zero.");
    property p_hold; acc && !pwrite |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("Read data moved after access.");
    // The acknowledge may only start while the link clock is low, else it would look like a start.
    property p_ackstart; $rose(sdaOe) |-> !sclIn; endproperty
    a_ackstart: assert property (p_ackstart) else $error("Acknowledge began with clock high.");
    property p_acklen; $rose(sdaOe) |-> sdaOe [*4] ##[1:20] !sdaOe; endproperty
    a_acklen: assert property (p_acklen) else $error("Acknowledge length wrong.");
    property p_pin; !sdaOut; endproperty
    a_pin: assert property (p_pin) else $error("Data pin driven high.");
    property p_clr; acc && pwrite && paddr == 8'h0C && pwdata[2:0] == 3'h7 |-> ##2 !system_control_irq; endproperty
    a_clr: assert property (p_clr) else $error("Interrupt stayed after clear.");
    property p_mask; acc && pwrite && paddr == 8'h10 && pwdata[2:0] == 3'h0 |-> ##2 !system_control_irq; endproperty
    a_mask: assert property (p_mask) else $error("Interrupt stayed after mask.");
    c_irq: cover property ($rose(system_control_irq));
    c_ack: cover property ($rose(sdaOe));
    c_err: cover property (pslverr);
endmodule : bbac_alarm_monitor

/* File: bbac_link_partner.sv */
`timescale 1ns/1ps
module bbac_link_partner (
    output logic sclOut,
    output logic sdaOut,
    input wire logic sdaBus
);
    // Both lines released, so the pull-ups hold them high between frames.
    initial begin
        sclOut = 1'b1;
        sdaOut = 1'b1;
    end
    // One notify frame of four bytes, first byte in the top of frame; acks bit 3 is the first byte.
    // The link clock only runs inside the frame, 120 ns low and 80 ns high.
    task automatic send_frame(input logic [31:0] frame, output logic [3:0] acks);
        #110 sdaOut = 1'b0;
        #100 sclOut = 1'b0;
        for (int b = 3; b >= 0; b--) begin
            for (int i = 8; i >= 0; i--) begin
                #60 sdaOut = (i == 0) ? 1'b1 : frame[b * 8 + i - 1];
                #60 sclOut = 1'b1;
                #40 if (i == 0) acks[b] = !sdaBus;
                #40 sclOut = 1'b0;
            end
        end
        #60 sdaOut = 1'b0;
        #60 sclOut = 1'b1;
        #100 sdaOut = 1'b1;
        #200;
    endtask : send_frame
endmodule : bbac_link_partner

/* File: testbench.sv */
`timescale 1ns/1ps
`include "bbac_params.svh"
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sdaOut;
    logic sdaOe;
    logic system_control_irq;
    logic [31:0] rdata;
    logic slvErr;
    logic [3:0] acks;
    logic [7:0] chg;
    int errTotal = 0;
    int nCompared = 0;
    wire logic sclLine;
    wire logic sdaTx;
    wire logic sdaBus;
    // Table rows: own address, originator byte, config, acks, status, info.
    logic [7:0] rowOwn [6] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h16};
    logic [7:0] rowSrc [6] = '{8'h12, 8'h12, 8'h14, 8'h14, 8'h14, 8'h12};
    logic [7:0] rowCfg [6] = '{8'h10, 8'h30, 8'h02, 8'h23, 8'h00, 8'h00};
    logic [3:0] rowAck [6] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h0};
    logic [2:0] rowSt [6] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h3, 3'h0};
    logic [11:0] rowInfo [6] = '{12'h121, 12'h101, 12'h601, 12'h601, 12'h0, 12'h0};
    // Open-drain wire: either party pulling low wins over the pull-up.
    assign sdaBus = sdaTx && !(sdaOe && !sdaOut);
    always #12.5 clk_sys = ~clk_sys;
    bbac_alarm_capture bbac_alarm_capture_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclIn(sclLine), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .system_control_irq(system_control_irq));
    bbac_link_partner bbac_link_partner_i (.sclOut(sclLine), .sdaOut(sdaTx), .sdaBus(sdaBus));
    task automatic stop_test();
        if (errTotal == 0 && nCompared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One bus transfer, entered just after a rising edge; the request holds until ready is seen.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        if (pready !== 1'b1) begin
            errTotal++;
            stop_test();
        end
        rdata = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask : rd
    task automatic frame(input logic [31:0] f);
        bbac_link_partner_i.send_frame(f, acks);
        @(posedge clk_sys);
    endtask : frame
    // The interrupt follows status one cycle late, so let two edges pass first.
    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, system_control_irq}, {31'h0, exp});
    endtask : chk_irq
    initial begin
        #1000000;
        errTotal++;
        stop_test();
    end
    initial begin
        chg = {`BBAC_CHARGER_ADDR, `BBAC_WRITE_BIT};
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(`BBAC_OFS_STATUS, 32'h0);
        rd(`BBAC_OFS_ALARM_ADDR, 32'h0);
        wr(`BBAC_OFS_ENABLE, 32'h7);
        wr(`BBAC_OFS_CONFIG, 32'h0);
        frame({8'h10, chg, 8'h34, 8'hA5});
        chk({28'h0, acks}, 32'hF);
        rd(`BBAC_OFS_ALARM_ADDR, {24'h0, chg});
        rd(`BBAC_OFS_ALARM_DATA, 32'hA534);
        rd(`BBAC_OFS_STATUS, 32'h1);
        chk_irq(1'b1);
        rd(`BBAC_OFS_INFO, {20'h0, 4'h1, `BBAC_CMD_CHARGER_STATE});
        // A second alarm while one is held must be refused and leave the capture alone.
        frame({8'h10, chg, 8'h00, 8'h00});
        chk({28'h0, acks}, 32'h0);
        rd(`BBAC_OFS_ALARM_DATA, 32'hA534);
        rd(`BBAC_OFS_STATUS, 32'h5);
        wr(`BBAC_OFS_ENABLE, 32'h0);
        chk_irq(1'b0);
        wr(`BBAC_OFS_ENABLE, 32'h7);
        wr(`BBAC_OFS_CLEAR, 32'h7);
        rd(`BBAC_OFS_STATUS, 32'h0);
        chk_irq(1'b0);
        wr(`BBAC_OFS_CONFIG, 32'h02);
        wr(`BBAC_OFS_CONFIG, 32'h15);
        rd(`BBAC_OFS_CONFIG, 32'h12);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, slvErr}, 32'h1);
        chk(rdata, 32'h0);
        for (int r = 0; r < 6; r++) begin
            wr(`BBAC_OFS_CONFIG, {24'h0, rowCfg[r]});
            frame({rowOwn[r], rowSrc[r], 8'h5A ^ 8'(r), 8'(r)});
            chk({28'h0, acks}, {28'h0, rowAck[r]});
            rd(`BBAC_OFS_STATUS, {29'h0, rowSt[r]});
            if (rowSt[r][0]) begin
                rd(`BBAC_OFS_ALARM_ADDR, {24'h0, rowSrc[r]});
                rd(`BBAC_OFS_ALARM_DATA, {16'h0, 8'(r), 8'h5A ^ 8'(r)});
            end
            if (rowSt[r] == 3'h1) begin
                rd(`BBAC_OFS_INFO, {20'h0, rowInfo[r]});
            end
            wr(`BBAC_OFS_CLEAR, 32'h7);
        end
        stop_test();
    end
endmodule : testbench
bind bbac_alarm_capture bbac_alarm_monitor bbac_alarm_monitor_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .system_control_irq(system_control_irq));
